// ### design/hybrid_tap_params.svh
// Purpose: constants for the upper hybrid tap coefficient bank
// Assumes: register index times four gives the AXI byte address
// Notes: definitions only
`ifndef HYBRID_TAP_PARAMS_SVH
`define HYBRID_TAP_PARAMS_SVH

// ----------------------------------------
// register indexes
// ----------------------------------------
`define TAP5_IDX 6'h31
`define TAP6_IDX 6'h32
`define TAP7_IDX 6'h33
`define TAP8_IDX 6'h34
`define RSVD_A_IDX 6'h35
`define RSVD_B_IDX 6'h36

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define COEFF_LSB 0
`define COEFF_MSB 7
`define TAP5_RST 8'h00
`define TAP6_RST 8'h00
`define TAP7_RST 8'h00
`define TAP8_RST 8'h00
`define RSVD_READ 32'h0000_0000

// ----------------------------------------
// bus
// ----------------------------------------
`define AXI_ADDR_W 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### design/hybrid_tap_pkg.sv
// Purpose: types shared by the hybrid tap coefficient bank
// Assumes: nothing beyond the params header
// Notes: no constants here, only types
package hybrid_tap_pkg;

  typedef logic [7:0] coeff_t;
  typedef logic [1:0] resp_t;
  typedef enum {SLOT_TAP, SLOT_RSVD, SLOT_NONE} slot_e;

endpackage : hybrid_tap_pkg

// ### design/tap_coeff_reg.sv
// Purpose: one eight-bit tap coefficient holding register
// Assumes: load is a one-cycle pulse on sys_clk
// Notes: new value appears the cycle after load
`timescale 1ns/1ns

module tap_coeff_reg #(
  parameter hybrid_tap_pkg::coeff_t RESET_VALUE = 8'h00
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire hybrid_tap_pkg::coeff_t load_data,
  output hybrid_tap_pkg::coeff_t coeff
);

  typedef struct packed {
    hybrid_tap_pkg::coeff_t value;
  } hold_s;

  hold_s state;
  hold_s next_state;

  always_comb begin
    next_state = state;
    if (load) begin
      next_state.value = load_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state.value <= RESET_VALUE;
    end else begin
      state <= next_state;
    end
  end

  assign coeff = state.value;

endmodule : tap_coeff_reg

// ### design/hybrid_tap_coeff_regs_upper.sv
// Purpose: AXI4-Lite bank holding hybrid filter taps five to eight
// Assumes: one write and one read outstanding at most
// Notes: reserved slots read zero and ignore writes
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "hybrid_tap_params.svh"

module hybrid_tap_coeff_regs_upper (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output hybrid_tap_pkg::resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output hybrid_tap_pkg::resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output hybrid_tap_pkg::coeff_t tap_five_coeff,
  output hybrid_tap_pkg::coeff_t tap_six_coeff,
  output hybrid_tap_pkg::coeff_t tap_seven_coeff,
  output hybrid_tap_pkg::coeff_t tap_eight_coeff,
  output logic [3:0] tap_active
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [`AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    hybrid_tap_pkg::coeff_t w_data;
    logic w_lane0;
    logic bvalid;
    hybrid_tap_pkg::resp_t bresp;
    logic rvalid;
    logic [31:0] rdata;
    hybrid_tap_pkg::resp_t rresp;
  } bus_s;

  localparam hybrid_tap_pkg::coeff_t TAP_RST [4] = '{`TAP5_RST, `TAP6_RST, `TAP7_RST, `TAP8_RST};

  bus_s st;
  bus_s next_st;
  hybrid_tap_pkg::coeff_t coeff [4];
  logic [3:0] load;
  logic commit;

  function automatic hybrid_tap_pkg::slot_e slot_of(input logic [5:0] idx);
    if (idx >= `TAP5_IDX && idx <= `TAP8_IDX) begin
      slot_of = hybrid_tap_pkg::SLOT_TAP;
    end else if (idx == `RSVD_A_IDX || idx == `RSVD_B_IDX) begin
      slot_of = hybrid_tap_pkg::SLOT_RSVD;
    end else begin
      slot_of = hybrid_tap_pkg::SLOT_NONE;
    end
  endfunction : slot_of

  // ----------------------------------------
  // coefficient storage
  // ----------------------------------------
  // write lands only once both halves are held, so a late wdata cannot tear a value
  assign commit = st.aw_held && st.w_held && !st.bvalid;

  for (genvar i = 0; i < 4; i++) begin : g_tap
    assign load[i] = commit && st.w_lane0 && (st.aw_addr[7:2] == 6'(`TAP5_IDX + i));
    tap_coeff_reg #(.RESET_VALUE(TAP_RST[i])) u_tap (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(load[i]),
      .load_data(st.w_data),
      .coeff(coeff[i])
    );
    assign tap_active[i] = (coeff[i] != 8'h00);
  end

  // lower taps are combined downstream with these four
  assign tap_five_coeff = coeff[0];
  assign tap_six_coeff = coeff[1];
  assign tap_seven_coeff = coeff[2];
  assign tap_eight_coeff = coeff[3];

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  assign s_axi_awready = !st.aw_held;
  assign s_axi_wready = !st.w_held;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  always_comb begin
    next_st = st;
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata[`COEFF_MSB:`COEFF_LSB];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // reserved slots swallow a stray write quietly; software should never send one
    if (commit) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = (slot_of(st.aw_addr[7:2]) == hybrid_tap_pkg::SLOT_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RESP_OKAY;
      next_st.rdata = `RSVD_READ;
      unique case (slot_of(s_axi_araddr[7:2]))
        hybrid_tap_pkg::SLOT_TAP: begin
          next_st.rdata = {24'h00_0000, coeff[2'(s_axi_araddr[7:2] - `TAP5_IDX)]};
        end
        hybrid_tap_pkg::SLOT_RSVD: begin
          next_st.rdata = `RSVD_READ;
        end
        hybrid_tap_pkg::SLOT_NONE: begin
          next_st.rresp = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  tap5_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    commit && st.w_lane0 && st.aw_addr[7:2] == `TAP5_IDX |=> tap_five_coeff == $past(st.w_data))
    else $error("tap five did not take written value");

  tap8_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    commit && st.w_lane0 && st.aw_addr[7:2] == `TAP8_IDX |=> tap_eight_coeff == $past(st.w_data)
      && $stable(tap_five_coeff) && $stable(tap_six_coeff) && $stable(tap_seven_coeff))
    else $error("tap eight write wrong or disturbed other taps");

  tap6_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == `TAP6_IDX
      |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(tap_six_coeff)} && s_axi_rresp == `RESP_OKAY)
    else $error("tap six readback mismatch");

  zero_tap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    commit && st.w_lane0 && st.aw_addr[7:2] == `TAP6_IDX && st.w_data == 8'h00 |=> !tap_active[1])
    else $error("zeroed tap six still active");

  reset_taps_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> tap_five_coeff == 8'h00 && tap_seven_coeff == 8'h00 && !tap_active[0] && !tap_active[2])
    else $error("tap five or seven not zero after reset");

  rsvd_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:2] == `RSVD_A_IDX || s_axi_araddr[7:2] == `RSVD_B_IDX)
      |=> s_axi_rvalid && s_axi_rresp == `RESP_OKAY)
    else $error("reserved read not answered okay");

  write_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    commit |=> s_axi_bvalid ##0 (s_axi_bvalid && !s_axi_bready) [*2] |=> s_axi_bvalid)
    else $error("write response dropped before bready");

  read_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed while stalled");

  unmapped_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h30 |=> s_axi_rresp == `RESP_SLVERR)
    else $error("unmapped read not refused");

  tap6_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    commit && st.w_lane0 && st.aw_addr[7:2] == `TAP6_IDX |=> tap_six_coeff == $past(st.w_data))
    else $error("tap six did not take written value");

  tap7_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    commit && st.w_lane0 && st.aw_addr[7:2] == `TAP7_IDX |=> tap_seven_coeff == $past(st.w_data))
    else $error("tap seven did not take written value");

  strobe_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    commit && !st.w_lane0 |=> $stable(tap_five_coeff) && $stable(tap_six_coeff)
      && $stable(tap_seven_coeff) && $stable(tap_eight_coeff))
    else $error("write with lane zero off changed a tap");

  unmapped_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    commit && slot_of(st.aw_addr[7:2]) == hybrid_tap_pkg::SLOT_NONE |=> s_axi_bresp == `RESP_SLVERR
      && $stable(tap_five_coeff) && $stable(tap_six_coeff)
      && $stable(tap_seven_coeff) && $stable(tap_eight_coeff))
    else $error("unmapped write not refused or stored");

  taps_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !commit |=> $stable(tap_five_coeff) && $stable(tap_six_coeff)
      && $stable(tap_seven_coeff) && $stable(tap_eight_coeff))
    else $error("tap changed without a write");

endmodule : hybrid_tap_coeff_regs_upper

// ### tb/tb_hybrid_tap_coeff_regs_upper.sv
// Purpose: self-checking bench for the upper hybrid tap coefficient bank
// Assumes: byte address is register index times four
// Notes: reserved slots are only read, never written
`timescale 1ns/1ns
`include "hybrid_tap_params.svh"

module tb_hybrid_tap_coeff_regs_upper;
  logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, taps_at_b, got;
  logic [3:0] wstrb, tap_active;
  hybrid_tap_pkg::resp_t bresp, rresp, resp;
  hybrid_tap_pkg::coeff_t c5, c6, c7, c8;
  int bad_count, n_tests;
  logic [7:0] vals [4] = '{8'h5a, 8'ha5, 8'h81, 8'h7e};

  hybrid_tap_coeff_regs_upper DUT (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tap_five_coeff(c5), .tap_six_coeff(c6), .tap_seven_coeff(c7), .tap_eight_coeff(c8),
    .tap_active(tap_active));

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // handshakes judged at the rising edge itself; stall holds bready or rready low that many edges
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] strb, input int stall);
    int n;
    logic b_t;
    n = 0;
    b_t = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= strb;
    wvalid <= 1'b1;
    bready <= (stall == 0);
    while (!b_t) begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      b_t = bvalid && bready;
      if (b_t) begin
        resp = bresp;
        taps_at_b = {c8, c7, c6, c5};
        bready <= 1'b0;
      end else if (n >= stall) begin
        bready <= 1'b1;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input int stall);
    int n;
    logic r_t;
    n = 0;
    r_t = 1'b0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (stall == 0);
    while (!r_t) begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      r_t = rvalid && rready;
      if (r_t) begin
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
      end else if (n >= stall) begin
        rready <= 1'b1;
      end
    end
  endtask : axi_read

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_values();
    check({c8, c7, c6, c5}, 32'h0000_0000);
    check({28'h0, tap_active}, 32'h0000_0000);
    axi_read({`TAP5_IDX, 2'b00}, 0);
    check(got, 32'h0000_0000);
    axi_read({`TAP7_IDX, 2'b00}, 0);
    check(got, 32'h0000_0000);
  endtask : reset_values

  // upper data bits set to show only the low byte is kept
  task automatic write_all_taps();
    for (int i = 0; i < 4; i++) begin
      axi_write({6'(`TAP5_IDX + i), 2'b00}, {24'hffff_ff, vals[i]}, 4'h1, 0);
      check({30'h0, resp}, {30'h0, `RESP_OKAY});
      check({24'h0, taps_at_b[8*i +: 8]}, {24'h0, vals[i]});
    end
    check({c8, c7, c6, c5}, {vals[3], vals[2], vals[1], vals[0]});
    for (int i = 0; i < 4; i++) begin
      axi_read({6'(`TAP5_IDX + i), 2'b00}, 0);
      check(got, {24'h0, vals[i]});
    end
    check({28'h0, tap_active}, 32'h0000_000f);
  endtask : write_all_taps

  task automatic zero_tap();
    axi_write({`TAP6_IDX, 2'b00}, 32'h0000_0000, 4'h1, 0);
    check({24'h0, c6}, 32'h0000_0000);
    check({28'h0, tap_active}, 32'h0000_000d);
  endtask : zero_tap

  // reserved slots read zero, but only the response is judged here
  task automatic odd_addresses();
    axi_read({`RSVD_A_IDX, 2'b00}, 0);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
    axi_read({`RSVD_B_IDX, 2'b00}, 0);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
    axi_read(8'hc0, 0);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    // stray write aimed at an unmapped index, never at a reserved one
    axi_write(8'hfc, 32'h0000_0033, 4'h1, 0);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    check({c8, c7, c6, c5}, {vals[3], vals[2], 8'h00, vals[0]});
  endtask : odd_addresses

  // slow bready and rready make the answers stand; lane 0 off leaves the tap alone
  task automatic slow_master();
    axi_write({`TAP8_IDX, 2'b00}, 32'h0000_0042, 4'h1, 4);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
    check({24'h0, c8}, 32'h0000_0042);
    axi_read({`TAP8_IDX, 2'b00}, 3);
    check(got, 32'h0000_0042);
    axi_write({`TAP5_IDX, 2'b00}, 32'h0000_0011, 4'h0, 0);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
    check({24'h0, c5}, {24'h0, vals[0]});
  endtask : slow_master

  // ----------------------------------------
  // clock, reset, sequence
  // ----------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    reset_values();
    write_all_taps();
    zero_tap();
    odd_addresses();
    slow_master();
    test_done();
  end

  // whole run needs under a hundred cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end
endmodule : tb_hybrid_tap_coeff_regs_upper
